// ==== core/prc_pkg.sv ====
// Constants and types shared by the power reduction controller
package prc_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_EDGE_CFG = 16'hf1c0;
  localparam logic [15:0] ADDR_SYS_CFG  = 16'hf1c4;
  localparam logic [15:0] ADDR_IRQ_CTRL = 16'hf1c8;
  localparam logic [15:0] ADDR_STATUS   = 16'hf1cc;
  localparam int          ADDR_W        = 16;
  // Field layout
  localparam int VARIANT_BIT  = 5;
  localparam int IRQ_EN_LSB   = 0;
  localparam int IRQ_FLAG_LSB = 8;
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_REFUSED   = 8;
  // Reset values
  localparam logic [15:0] EDGE_CFG_RST = 16'h0000;
  localparam logic [15:0] SYS_CFG_RST  = 16'h0000;
  localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
  // Edge field codes
  localparam logic [1:0] EDGE_OFF  = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int WAKE_PULSE_NS  = 40;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                  (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES    = 3;
  // Controller states
  typedef enum logic [6:0] {
    ST_RUN      = 7'b0000001,
    ST_PEND     = 7'b0000010,
    ST_IDLE     = 7'b0000100,
    ST_PD_PROT  = 7'b0001000,
    ST_PD_INT   = 7'b0010000,
    ST_PD_DELAY = 7'b0100000,
    ST_WAKE_ONE = 7'b1000000
  } prc_state_t;
  // Pending protected instruction
  typedef enum logic [1:0] {
    REQ_NONE = 2'b00,
    REQ_IDLE = 2'b01,
    REQ_PD   = 2'b10
  } prc_req_t;
endpackage : prc_pkg

// ==== core/prc_power_ctrl.sv ====
// Power reduction controller: idle and power-down sequencing with APB registers
//
// What this block does
// - Idle halts CPU execution; peripherals keep their clock.
// - Power-down stops the CPU, peripheral and watchdog clocks.
// - Only the protected idle or power-down instruction starts a low-power mode.
// - Pending external bus actions finish before any low-power entry.
// - Entry refused if ready handshake enabled but not seen on last access.
// - Any interrupt request ends idle; CPU resumes after idle instruction.
// - Peripheral event transfer keeps idle; a failed transfer ends idle.
// - Variant select bit 5 zero chooses protected power-down.
// - Protected power-down entered only while the NMI pin is low.
// - Protected power-down is left only by hardware reset.
// - Variant select bit 5 one chooses interruptible power-down.
// - Interruptible entry only if all enabled fast pins are inactive.
// - Interruptible power-down ends on reset or a fast pin request.
// - Fast pins are edge interrupts normally, levels for power-down decisions.
// - Wake by a fast pin works even with its interrupt disabled.
// - Qualified wake restarts oscillator and PLL and enables delay pull-down.
// - Clocks stay gated until the delay-pin comparator reports low.
// - Enabled waking interrupt is serviced after wake, then execution continues.
// - One instruction after power-down executes before the service call.
// - Disabled waking interrupt leaves its request flag set until software clears.
`timescale 1ns/100ps
module prc_power_ctrl #(
  parameter int N_PINS = 8
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // CPU side
  input  wire logic                       idle_instr,
  input  wire logic                       power_down_instr,
  input  wire logic                       ext_bus_idle,
  input  wire logic                       ready_enabled,
  input  wire logic                       ready_seen,
  input  wire logic                       irq_request,
  input  wire logic                       pec_xfer_fail,
  input  wire logic                       instr_retired,
  output logic                            cpu_halt,
  output logic                            cpu_clk_en,
  output logic                            periph_clk_en,
  output logic                            wdt_clk_en,
  output logic                            instr_refused,
  output logic                            irq_hold,
  output logic      [N_PINS-1:0]          irq_pending,
  // Pins
  input  wire logic                       nmi_pin_n,
  input  wire logic [N_PINS-1:0]          fast_ext_irq_pin,
  input  wire logic                       wake_delay_below,
  output logic                            osc_pll_en,
  output logic                            wake_delay_pulldown_en,
  output logic                            wake_delay_pullup_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Edge field decode

  // Level that permits entry
  function automatic logic pin_inactive(input logic [1:0] mode, input logic lvl);
    unique case (mode)
      prc_pkg::EDGE_RISE: pin_inactive = !lvl;
      prc_pkg::EDGE_FALL: pin_inactive = lvl;
      default:            pin_inactive = 1'b1;
    endcase
  endfunction : pin_inactive

  // Level that wakes, against the level held at entry
  function automatic logic pin_wakes(input logic [1:0] mode, input logic lvl,
                                     input logic at_entry);
    unique case (mode)
      prc_pkg::EDGE_RISE: pin_wakes = lvl;
      prc_pkg::EDGE_FALL: pin_wakes = !lvl;
      prc_pkg::EDGE_BOTH: pin_wakes = lvl != at_entry;
      default:            pin_wakes = 1'b0;
    endcase
  endfunction : pin_wakes

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  localparam int NS = prc_pkg::SYNC_STAGES;
  logic [NS-1:0]     nmi_sync;
  logic [NS-1:0]     dly_sync;
  logic              nmi_lvl;
  logic              dly_lvl;
  logic [N_PINS-1:0] pin_lvl;
  logic [N_PINS-1:0] pin_prev;

  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_sync <= '1;
      dly_sync <= '0;
    end else begin
      nmi_sync <= {nmi_sync[NS-2:0], nmi_pin_n};
      dly_sync <= {dly_sync[NS-2:0], wake_delay_below};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_lvl <= 1'b1;
      dly_lvl <= 1'b0;
    end else begin
      if (nmi_sync[1] == nmi_sync[2]) nmi_lvl <= nmi_sync[2];
      if (dly_sync[1] == dly_sync[2]) dly_lvl <= dly_sync[2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_pin
      // Per-pin flops keep one driver for each shared vector
      logic [NS-1:0] sync_q;
      logic          lvl_q;
      logic          prev_q;
      always_ff @(posedge clock) begin
        if (rst) begin
          sync_q <= '0;
          lvl_q  <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[NS-2:0], fast_ext_irq_pin[gi]};
          if (sync_q[1] == sync_q[2]) lvl_q <= sync_q[2];
          prev_q <= lvl_q;
        end
      end
      assign pin_lvl[gi]  = lvl_q;
      assign pin_prev[gi] = prev_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0]       ext_irq_edge_config;
  logic [15:0]       system_config_reg;
  logic [N_PINS-1:0] irq_enable;
  logic [N_PINS-1:0] irq_request_flag;
  logic              refused_seen;
  logic              power_down_variant_select;
  prc_pkg::prc_state_t state;

  assign power_down_variant_select = system_config_reg[prc_pkg::VARIANT_BIT];

  logic [prc_pkg::ADDR_W-1:0] addr;
  logic                        wr_acc;
  logic                        hit;
  assign addr   = paddr[prc_pkg::ADDR_W-1:0];
  assign wr_acc = psel && penable && pready && pwrite;
  assign hit    = paddr[31:prc_pkg::ADDR_W] == '0 &&
                  (addr == prc_pkg::ADDR_EDGE_CFG || addr == prc_pkg::ADDR_SYS_CFG ||
                   addr == prc_pkg::ADDR_IRQ_CTRL || addr == prc_pkg::ADDR_STATUS);

  always_ff @(posedge clock) begin
    if (rst) begin
      ext_irq_edge_config <= prc_pkg::EDGE_CFG_RST;
      system_config_reg   <= prc_pkg::SYS_CFG_RST;
      irq_enable          <= N_PINS'(prc_pkg::IRQ_EN_RST);
    end else if (wr_acc && paddr[31:prc_pkg::ADDR_W] == '0) begin
      if (addr == prc_pkg::ADDR_EDGE_CFG) ext_irq_edge_config <= pwdata[15:0];
      if (addr == prc_pkg::ADDR_SYS_CFG)  system_config_reg   <= pwdata[15:0];
      if (addr == prc_pkg::ADDR_IRQ_CTRL)
        irq_enable <= pwdata[prc_pkg::IRQ_EN_LSB +: N_PINS];
    end
  end

  // APB answer: ready in the first access cycle, no wait states
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= '0;
      if (psel && !penable && paddr[31:prc_pkg::ADDR_W] == '0) begin
        unique case (addr)
          prc_pkg::ADDR_EDGE_CFG: prdata <= {16'h0000, ext_irq_edge_config};
          prc_pkg::ADDR_SYS_CFG:  prdata <= {16'h0000, system_config_reg};
          prc_pkg::ADDR_IRQ_CTRL: begin
            prdata[prc_pkg::IRQ_EN_LSB +: N_PINS]   <= irq_enable;
            prdata[prc_pkg::IRQ_FLAG_LSB +: N_PINS] <= irq_request_flag;
          end
          prc_pkg::ADDR_STATUS: begin
            prdata[prc_pkg::ST_MODE_LSB +: 7] <= state;
            prdata[prc_pkg::ST_REFUSED]       <= refused_seen;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin decisions

  logic [N_PINS-1:0] pin_entry_lvl;
  logic [N_PINS-1:0] pin_ok_entry;
  logic [N_PINS-1:0] pin_wake_now;
  logic [N_PINS-1:0] pin_edge;
  logic [7:0]        wake_cnt;
  logic              wake_qual;

  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_dec
      logic [1:0] mode;
      assign mode = ext_irq_edge_config[2*gi +: 2];
      // Levels decide entry and wake, edges raise normal interrupts
      assign pin_ok_entry[gi] = pin_inactive(mode, pin_lvl[gi]);
      assign pin_wake_now[gi] = pin_wakes(mode, pin_lvl[gi], pin_entry_lvl[gi]);
      assign pin_edge[gi]     = pin_wakes(mode, pin_lvl[gi], pin_prev[gi]) &&
                                (pin_lvl[gi] != pin_prev[gi]);
    end
  endgenerate

  // Wake level must persist the minimum pulse width
  always_ff @(posedge clock) begin
    if (rst || state != prc_pkg::ST_PD_INT || pin_wake_now == '0) begin
      wake_cnt <= '0;
    end else if (wake_cnt < 8'(prc_pkg::WAKE_PULSE_CYC)) begin
      wake_cnt <= wake_cnt + 8'h01;
    end
  end
  assign wake_qual = (pin_wake_now != '0) &&
                     (wake_cnt + 8'h01 >= 8'(prc_pkg::WAKE_PULSE_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  prc_pkg::prc_req_t req;
  prc_pkg::prc_state_t next_state;
  logic                refuse;
  logic                enter_ok;

  always_comb begin
    enter_ok = !(ready_enabled && !ready_seen);
    if (req == prc_pkg::REQ_PD) begin
      if (!power_down_variant_select) enter_ok = enter_ok && !nmi_lvl;
      else enter_ok = enter_ok && (pin_ok_entry == '1);
    end
  end

  always_comb begin
    next_state = state;
    refuse     = 1'b0;
    unique case (state)
      prc_pkg::ST_RUN:
        if (idle_instr || power_down_instr) next_state = prc_pkg::ST_PEND;
      prc_pkg::ST_PEND:
        if (ext_bus_idle) begin
          if (!enter_ok) begin
            next_state = prc_pkg::ST_RUN;
            refuse     = 1'b1;
          end else if (req == prc_pkg::REQ_IDLE) begin
            next_state = prc_pkg::ST_IDLE;
          end else if (!power_down_variant_select) begin
            next_state = prc_pkg::ST_PD_PROT;
          end else begin
            next_state = prc_pkg::ST_PD_INT;
          end
        end
      // Transfers that succeed leave the CPU idle
      prc_pkg::ST_IDLE:
        if (irq_request || pec_xfer_fail) next_state = prc_pkg::ST_RUN;
      // Only rst leaves this state
      prc_pkg::ST_PD_PROT: next_state = prc_pkg::ST_PD_PROT;
      prc_pkg::ST_PD_INT:
        if (wake_qual) next_state = prc_pkg::ST_PD_DELAY;
      prc_pkg::ST_PD_DELAY:
        if (dly_lvl) next_state = prc_pkg::ST_WAKE_ONE;
      prc_pkg::ST_WAKE_ONE:
        if (instr_retired) next_state = prc_pkg::ST_RUN;
      default: next_state = prc_pkg::ST_RUN;
    endcase
  end

  // Reset pin is rst itself, so both variants end there
  always_ff @(posedge clock) begin
    if (rst) state <= prc_pkg::ST_RUN;
    else     state <= next_state;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      req <= prc_pkg::REQ_NONE;
    end else if (state == prc_pkg::ST_RUN) begin
      if (power_down_instr)  req <= prc_pkg::REQ_PD;
      else if (idle_instr)   req <= prc_pkg::REQ_IDLE;
      else                   req <= prc_pkg::REQ_NONE;
    end
  end

  // Entry levels kept for any-change wake
  always_ff @(posedge clock) begin
    if (rst) pin_entry_lvl <= '0;
    else if (next_state == prc_pkg::ST_PD_INT && state != prc_pkg::ST_PD_INT)
      pin_entry_lvl <= pin_lvl;
  end

  // Set wins over a software clear
  logic [N_PINS-1:0] flag_set;
  logic [N_PINS-1:0] flag_clr;

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    if (state == prc_pkg::ST_PD_INT && wake_qual) flag_set = pin_wake_now;
    else if (state != prc_pkg::ST_PD_DELAY) flag_set = pin_edge;
    if (wr_acc && addr == prc_pkg::ADDR_IRQ_CTRL && paddr[31:prc_pkg::ADDR_W] == '0)
      flag_clr = pwdata[prc_pkg::IRQ_FLAG_LSB +: N_PINS];
  end

  always_ff @(posedge clock) begin
    if (rst) irq_request_flag <= '0;
    else     irq_request_flag <= (irq_request_flag & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clock) begin
    if (rst)         refused_seen <= 1'b0;
    else if (refuse) refused_seen <= 1'b1;
    else if (wr_acc && addr == prc_pkg::ADDR_STATUS && paddr[31:prc_pkg::ADDR_W] == '0 &&
             pwdata[prc_pkg::ST_REFUSED])
      refused_seen <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic next_pd;
  assign next_pd = next_state == prc_pkg::ST_PD_PROT || next_state == prc_pkg::ST_PD_INT ||
                   next_state == prc_pkg::ST_PD_DELAY;

  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_halt      <= 1'b0;
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      wdt_clk_en    <= 1'b1;
      instr_refused <= 1'b0;
    end else begin
      cpu_halt      <= next_state == prc_pkg::ST_IDLE || next_pd;
      cpu_clk_en    <= !next_pd && next_state != prc_pkg::ST_IDLE;
      periph_clk_en <= !next_pd;
      wdt_clk_en    <= !next_pd;
      instr_refused <= refuse;
    end
  end

  // Oscillator stays off until a wake qualifies
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_pll_en             <= 1'b1;
      wake_delay_pulldown_en <= 1'b0;
      wake_delay_pullup_en   <= 1'b0;
    end else begin
      osc_pll_en             <= !(next_state == prc_pkg::ST_PD_PROT ||
                                  next_state == prc_pkg::ST_PD_INT);
      wake_delay_pulldown_en <= next_state == prc_pkg::ST_PD_DELAY;
      wake_delay_pullup_en   <= power_down_variant_select && !next_pd;
    end
  end

  // Service held back one instruction after wake
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_hold    <= 1'b0;
      irq_pending <= '0;
    end else begin
      irq_hold    <= next_state == prc_pkg::ST_WAKE_ONE || next_pd;
      irq_pending <= irq_request_flag & irq_enable;
    end
  end

endmodule : prc_power_ctrl

// ==== sim/prc_power_ctrl_props.sv ====
// Port-level assertions for the power reduction controller
`timescale 1ns/100ps
module prc_power_ctrl_props #(
  parameter int N_PINS = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic ext_bus_idle,
  input wire logic ready_enabled,
  input wire logic ready_seen,
  input wire logic irq_request,
  input wire logic pec_xfer_fail,
  input wire logic instr_retired,
  input wire logic cpu_halt,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic wdt_clk_en,
  input wire logic irq_hold,
  input wire logic osc_pll_en,
  input wire logic wake_delay_pulldown_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////
  idle_clk_keep_a: assert property (cpu_halt && periph_clk_en |-> !cpu_clk_en && wdt_clk_en)
    else $error("idle clock enables wrong");
  pd_clk_stop_a: assert property (!periph_clk_en |-> cpu_halt && !cpu_clk_en && !wdt_clk_en)
    else $error("power-down clock enables wrong");
  entry_bus_done_a: assert property ($rose(cpu_halt) |-> $past(ext_bus_idle))
    else $error("entry with external bus busy");
  entry_ready_a: assert property ($rose(cpu_halt) |-> !$past(ready_enabled) || $past(ready_seen))
    else $error("entry without ready seen");
  idle_irq_exit_a: assert property (cpu_halt && periph_clk_en && irq_request |=> !cpu_halt)
    else $error("interrupt did not end idle");
  idle_fail_exit_a: assert property (cpu_halt && periph_clk_en && pec_xfer_fail |=> !cpu_halt)
    else $error("failed transfer did not end idle");
  wake_restart_a: assert property ($rose(osc_pll_en) |-> wake_delay_pulldown_en || $past(rst))
    else $error("oscillator restart without pull-down");
  gate_hold_a: assert property (wake_delay_pulldown_en |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks open before delay pin low");
  gate_release_a: assert property ($fell(wake_delay_pulldown_en) && !$past(rst) |-> ##[0:1] cpu_clk_en)
    else $error("clocks not opened after delay");
  one_instr_a: assert property (irq_hold && cpu_clk_en |=> irq_hold != $past(instr_retired))
    else $error("hold window not one instruction");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
endmodule : prc_power_ctrl_props

bind prc_power_ctrl prc_power_ctrl_props #(.N_PINS(N_PINS)) prc_power_ctrl_props_inst (
  .clock, .rst, .psel, .penable, .pready, .ext_bus_idle, .ready_enabled, .ready_seen,
  .irq_request, .pec_xfer_fail, .instr_retired, .cpu_halt, .cpu_clk_en, .periph_clk_en,
  .wdt_clk_en, .irq_hold, .osc_pll_en, .wake_delay_pulldown_en
);

// ==== sim/prc_cpu_model.sv ====
// CPU core model issuing protected power instructions
`timescale 1ns/100ps
module prc_cpu_model (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              go,
  input  wire prc_pkg::prc_req_t op,
  input  wire logic              slow,
  input  wire logic              cpu_clk_en,
  output logic                   idle_instr,
  output logic                   power_down_instr,
  output logic                   instr_retired
);
  logic [2:0] run_cnt;
  //////////////////////////////////////////////////
  // Only a running core fetches instructions
  always_ff @(posedge clock) begin
    idle_instr       <= go && cpu_clk_en && !rst && op == prc_pkg::REQ_IDLE;
    power_down_instr <= go && cpu_clk_en && !rst && op == prc_pkg::REQ_PD;
  end
  // Slow core retires every eighth cycle to stretch the hold window
  always_ff @(posedge clock) begin
    if (rst || !cpu_clk_en) begin
      run_cnt       <= 3'h0;
      instr_retired <= 1'b0;
    end else begin
      run_cnt       <= run_cnt + 3'h1;
      instr_retired <= slow ? run_cnt == 3'h3 : 1'b1;
    end
  end
endmodule : prc_cpu_model

// ==== sim/prc_power_ctrl_tb.sv ====
// Self-checking bench for the power reduction controller
`timescale 1ns/100ps
module prc_power_ctrl_tb;
  logic              clock, rst, psel, penable, pwrite, pready, pslverr, err, ref_seen;
  logic [31:0]       paddr, pwdata, prdata, rdv;
  logic              idle_instr, power_down_instr, ext_bus_idle, ready_enabled, ready_seen;
  logic              irq_request, pec_xfer_fail, instr_retired, cpu_halt, cpu_clk_en, go, slow;
  logic              periph_clk_en, wdt_clk_en, instr_refused, irq_hold, nmi_pin_n;
  logic              wake_delay_below, osc_pll_en, wake_delay_pulldown_en, wake_delay_pullup_en;
  logic [7:0]        irq_pending, fast_ext_irq_pin, rc;
  prc_pkg::prc_req_t op;
  int                miscompares, checked, cyc;

  prc_power_ctrl #(.N_PINS(8)) prc_power_ctrl_inst (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .idle_instr, .power_down_instr, .ext_bus_idle, .ready_enabled, .ready_seen,
    .irq_request, .pec_xfer_fail, .instr_retired, .cpu_halt, .cpu_clk_en, .periph_clk_en,
    .wdt_clk_en, .instr_refused, .irq_hold, .irq_pending, .nmi_pin_n, .fast_ext_irq_pin,
    .wake_delay_below, .osc_pll_en, .wake_delay_pulldown_en, .wake_delay_pullup_en
  );
  prc_cpu_model prc_cpu_model_inst (
    .clock, .rst, .go, .op, .slow, .cpu_clk_en, .idle_instr, .power_down_instr, .instr_retired
  );
  //////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      final_report;
    end
  end
  // Delay-pin capacitor: comparator trips eleven cycles into discharge
  always @(posedge clock) begin
    if (wake_delay_pulldown_en !== 1'b1) begin
      rc <= 8'h00;
      wake_delay_below <= 1'b0;
    end else begin
      rc <= rc + 8'h01;
      wake_delay_below <= wake_delay_below | (rc == 8'h0a);
    end
  end
  //////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task final_report;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {16'h0000, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, e);
  endtask : rd
  task do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset
  // Issue one instruction, then watch eight cycles for a refusal
  task issue(input prc_pkg::prc_req_t o);
    @(posedge clock);
    op <= o;
    go <= 1'b1;
    ref_seen = 1'b0;
    @(posedge clock);
    go <= 1'b0;
    repeat (8) begin
      @(posedge clock);
      ref_seen |= instr_refused === 1'b1;
    end
  endtask : issue
  //////////////////////////////////////////////////
  task t_regs;
    rd(prc_pkg::ADDR_EDGE_CFG, {16'h0, prc_pkg::EDGE_CFG_RST}, "edge rst");
    rd(prc_pkg::ADDR_SYS_CFG, {16'h0, prc_pkg::SYS_CFG_RST}, "sys rst");
    apb(1'b1, prc_pkg::ADDR_EDGE_CFG, 32'hffff_a5c3);
    rd(prc_pkg::ADDR_EDGE_CFG, 32'h0000_a5c3, "edge rw");
    apb(1'b1, prc_pkg::ADDR_EDGE_CFG, 32'h0);
    rd(16'hf1d0, 32'h0, "unmapped data");
    chk("unmapped err", err, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  task t_idle;
    @(posedge clock);
    ext_bus_idle <= 1'b0;
    issue(prc_pkg::REQ_IDLE);
    chk("bus busy", cpu_halt, 1'b0);
    ext_bus_idle <= 1'b1;
    repeat (3) @(posedge clock);
    chk("idle cpu", cpu_clk_en, 1'b0);
    chk("idle periph", periph_clk_en, 1'b1);
    rd(prc_pkg::ADDR_STATUS, 32'h4, "idle state");
    irq_request <= 1'b1;
    @(posedge clock);
    irq_request <= 1'b0;
    repeat (2) @(posedge clock);
    chk("irq exit", cpu_halt, 1'b0);
    issue(prc_pkg::REQ_IDLE);
    chk("idle again", cpu_halt, 1'b1);
    pec_xfer_fail <= 1'b1;
    @(posedge clock);
    pec_xfer_fail <= 1'b0;
    repeat (2) @(posedge clock);
    chk("fail exit", cpu_halt, 1'b0);
    $display("t_idle done");
  endtask : t_idle
  task t_refuse;
    @(posedge clock);
    ready_enabled <= 1'b1;
    ready_seen <= 1'b0;
    issue(prc_pkg::REQ_IDLE);
    chk("refused", ref_seen, 1'b1);
    rd(prc_pkg::ADDR_STATUS, 32'h101, "sticky");
    apb(1'b1, prc_pkg::ADDR_STATUS, 32'h100);
    ready_seen <= 1'b1;
    $display("t_refuse done");
  endtask : t_refuse
  task t_prot;
    issue(prc_pkg::REQ_PD);
    chk("nmi high", ref_seen, 1'b1);
    nmi_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    issue(prc_pkg::REQ_PD);
    chk("pd periph", periph_clk_en, 1'b0);
    chk("pd wdt", wdt_clk_en, 1'b0);
    fast_ext_irq_pin <= 8'hff;
    irq_request <= 1'b1;
    repeat (6) @(posedge clock);
    rd(prc_pkg::ADDR_STATUS, 32'h108, "stay prot");
    fast_ext_irq_pin <= 8'h00;
    irq_request <= 1'b0;
    do_reset;
    @(posedge clock);
    chk("rst wake", periph_clk_en, 1'b1);
    nmi_pin_n <= 1'b1;
    $display("t_prot done");
  endtask : t_prot
  task t_int_refuse;
    apb(1'b1, prc_pkg::ADDR_SYS_CFG, 32'h20);
    apb(1'b1, prc_pkg::ADDR_EDGE_CFG, 32'h1);
    fast_ext_irq_pin[0] <= 1'b1;
    repeat (5) @(posedge clock);
    issue(prc_pkg::REQ_PD);
    chk("pin active", ref_seen, 1'b1);
    fast_ext_irq_pin[0] <= 1'b0;
    apb(1'b1, prc_pkg::ADDR_IRQ_CTRL, 32'hff00);
    $display("t_int_refuse done");
  endtask : t_int_refuse
  task t_wake(input int p, input logic [1:0] m, input logic en);
    int   i;
    logic act;
    act = m != prc_pkg::EDGE_FALL;
    @(posedge clock);
    fast_ext_irq_pin[p] <= !act;
    repeat (5) @(posedge clock);
    apb(1'b1, prc_pkg::ADDR_SYS_CFG, 32'h1 << prc_pkg::VARIANT_BIT);
    apb(1'b1, prc_pkg::ADDR_EDGE_CFG, {30'h0, m} << (2 * p));
    apb(1'b1, prc_pkg::ADDR_IRQ_CTRL, {31'h0, en} << p);
    chk("pullup", wake_delay_pullup_en, 1'b1);
    issue(prc_pkg::REQ_PD);
    chk("pd osc", osc_pll_en, 1'b0);
    fast_ext_irq_pin[p] <= act;
    repeat (3) @(posedge clock);
    fast_ext_irq_pin[p] <= !act;
    repeat (6) @(posedge clock);
    chk("wake osc", osc_pll_en, 1'b1);
    chk("pulldown", wake_delay_pulldown_en, 1'b1);
    chk("gated", cpu_clk_en, 1'b0);
    for (i = 0; i < 40 && cpu_clk_en !== 1'b1; i++) @(posedge clock);
    chk("hold", irq_hold, 1'b1);
    repeat (8) @(posedge clock);
    chk("hold off", irq_hold, 1'b0);
    rd(prc_pkg::ADDR_IRQ_CTRL, ({31'h0, en} << p) | (32'h100 << p), "flag");
    chk("pending", irq_pending, {31'h0, en} << p);
    apb(1'b1, prc_pkg::ADDR_IRQ_CTRL, 32'hff00);
    rd(prc_pkg::ADDR_IRQ_CTRL, 32'h0, "flag clear");
    $display("t_wake %0d done", p);
  endtask : t_wake
  //////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, go, irq_request, pec_xfer_fail, ready_enabled} = '0;
    {rst, slow, ready_seen, ext_bus_idle, nmi_pin_n} = '1;
    {paddr, pwdata, fast_ext_irq_pin} = '0;
    op = prc_pkg::REQ_NONE;
    do_reset;
    t_regs;
    t_idle;
    t_refuse;
    t_prot;
    t_int_refuse;
    t_wake(0, prc_pkg::EDGE_RISE, 1'b0);
    t_wake(1, prc_pkg::EDGE_FALL, 1'b1);
    slow <= 1'b0;
    t_wake(2, prc_pkg::EDGE_BOTH, 1'b1);
    final_report;
  end
endmodule : prc_power_ctrl_tb
